// *** include/saw_pkg.sv ***
package saw_pkg;

   // ----------------------------------------------------------------
   // register map (byte offsets, byte-wide registers)
   // ----------------------------------------------------------------
   localparam logic [7:0] OFS_BAT_RUN_TIME  = 8'h01;
   localparam logic [7:0] OFS_SERIAL_PORT   = 8'h02;
   localparam logic [7:0] OFS_STILL_ALIVE   = 8'h05;

   // ----------------------------------------------------------------
   // values and reset values
   // ----------------------------------------------------------------
   localparam logic [7:0] WD_DISABLE        = 8'hFF;
   localparam logic [7:0] WD_SAFE_SHUTDOWN  = 8'h00;
   localparam logic [7:0] WD_RESET_VAL      = 8'hFF;
   localparam logic [7:0] SERIAL_OFF        = 8'h00;
   localparam logic [7:0] SERIAL_ON         = 8'h01;
   localparam logic [7:0] SERIAL_RESET_VAL  = 8'h00;
   localparam logic [7:0] BAT_RESET_VAL     = 8'h00;
   localparam logic [7:0] BAT_TIMER_OFF     = 8'hFF;
   localparam int         SERIAL_BAUD       = 115200;

   // ----------------------------------------------------------------
   // timing
   // ----------------------------------------------------------------
   localparam int         CLK_HZ            = 50000000;
   localparam int         WD_TICK_S         = 1;
   localparam int         TICK_CYCLES       = WD_TICK_S * CLK_HZ;
   localparam logic [15:0] BAT_STEP_S       = 16'h003C;

   // ----------------------------------------------------------------
   // carriers
   // ----------------------------------------------------------------
   typedef struct packed {
      logic [7:0] addr;
      logic       wr;
      logic       rd;
      logic [7:0] wdata;
   } saw_regreq_t;

   typedef struct packed {
      logic       wr;
      logic [7:0] addr;
      logic [7:0] data;
   } saw_nvmwr_t;

endpackage

// *** rtl/saw_still_alive.sv ***
`timescale 1ns/100ps
// Notes on behaviour
// RQ1: countdown reads live value, read changes nothing
// RQ2: write 01..FE enables, loads, counts per second
// RQ3: enabled count reaching zero resets host
// RQ4: writing zero starts safe shutdown and restart; the code only pulses safeShutdown and turns the countdown off, with no restart
// RQ5: host reloads countdown before it expires
// RQ6: watchdog runs on battery or cable
// RQ7: write FF disables; disabled after power-up
// RQ8: serial port off by default, 0x01 enables
// RQ9: serial setting change committed to non-volatile store
// RQ10: battery run time 60 s plus setting*60 s
// RQ11: push button after battery shutdown restarts system
module saw_still_alive #(
   parameter int TICK_CYCLES = saw_pkg::TICK_CYCLES
) (
   // clock and reset
   input  wire logic                 sys_clk,
   input  wire logic                 resetn,
   // register port
   input  wire saw_pkg::saw_regreq_t regReq,
   output logic [7:0]                regRdData,
   output logic                      regRdValid,
   // board pins
   input  wire logic                 onBattery,
   input  wire logic                 funcButtonN,
   // host control
   output logic                      hostHwReset,
   output logic                      safeShutdown,
   output logic                      batShutdown,
   output logic                      hostRestart,
   output logic                      serialEnable,
   // non-volatile store
   output saw_pkg::saw_nvmwr_t       nvmWrite
);

   // ----------------------------------------------------------------
   // reset release
   // ----------------------------------------------------------------
   logic [1:0] rstSync_reg;
   logic       rstN;

   always_ff @(posedge sys_clk or negedge resetn)
   begin
      if (!resetn)
         rstSync_reg <= 2'b00;
      else
         rstSync_reg <= {rstSync_reg[0], 1'b1};
   end
   assign rstN = rstSync_reg[1];

   // ----------------------------------------------------------------
   // pin synchronisers, change accepted once stages 2 and 3 agree
   // ----------------------------------------------------------------
   logic [2:0] batSync_reg;
   logic [2:0] btnSync_reg;
   logic       batLevel_reg;
   logic       btnLevel_reg;
   logic       btnPrev_reg;
   logic       btnPress;

   always_ff @(posedge sys_clk or negedge rstN)
   begin
      if (!rstN)
      begin
         batSync_reg  <= 3'b000;
         btnSync_reg  <= 3'b111;
         batLevel_reg <= 1'b0;
         btnLevel_reg <= 1'b1;
         btnPrev_reg  <= 1'b1;
      end
      else
      begin
         batSync_reg <= {batSync_reg[1:0], onBattery};
         btnSync_reg <= {btnSync_reg[1:0], funcButtonN};
         if (batSync_reg[1] == batSync_reg[2])
            batLevel_reg <= batSync_reg[2];
         if (btnSync_reg[1] == btnSync_reg[2])
            btnLevel_reg <= btnSync_reg[2];
         btnPrev_reg <= btnLevel_reg;
      end
   end
   assign btnPress = btnPrev_reg && !btnLevel_reg;

   // ----------------------------------------------------------------
   // one-second timebase
   // ----------------------------------------------------------------
   logic secTick;

   saw_tick_gen #(
      .CYCLES (TICK_CYCLES)
   ) u_tick (
      .sysClk (sys_clk),
      .rstN   (rstN),
      .tick   (secTick)
   );

   // ----------------------------------------------------------------
   // register decode
   // ----------------------------------------------------------------
   function automatic logic hit(input saw_pkg::saw_regreq_t r, input logic [7:0] ofs);
      hit = r.wr && (r.addr == ofs);
   endfunction

   logic wdWr;
   logic serWr;
   logic batWr;
   assign wdWr  = hit(regReq, saw_pkg::OFS_STILL_ALIVE);
   assign serWr = hit(regReq, saw_pkg::OFS_SERIAL_PORT);
   assign batWr = hit(regReq, saw_pkg::OFS_BAT_RUN_TIME);

   // ----------------------------------------------------------------
   // still-alive countdown
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {
      WD_OFF = 2'b01,
      WD_RUN = 2'b10
   } saw_wd_state_t;

   saw_wd_state_t wdState_reg;
   logic [7:0]    wdCount_reg;

   // counts on either power source: nothing here looks at batLevel_reg
   always_ff @(posedge sys_clk or negedge rstN) // RQ6
   begin
      if (!rstN)
      begin
         wdState_reg <= WD_OFF;                  // RQ7
         wdCount_reg <= saw_pkg::WD_RESET_VAL;   // RQ7
         hostHwReset <= 1'b0;
         safeShutdown <= 1'b0;
      end
      else
      begin
         hostHwReset  <= 1'b0;
         safeShutdown <= 1'b0;
         if (wdWr)
         begin
            unique case (regReq.wdata)
               saw_pkg::WD_DISABLE:
               begin
                  wdState_reg <= WD_OFF;                 // RQ7
                  wdCount_reg <= saw_pkg::WD_DISABLE;
               end
               saw_pkg::WD_SAFE_SHUTDOWN:
               begin
                  safeShutdown <= 1'b1;                  // RQ4
                  wdState_reg  <= WD_OFF;
                  wdCount_reg  <= saw_pkg::WD_DISABLE;
               end
               default:
               begin
                  wdState_reg <= WD_RUN;                 // RQ2
                  wdCount_reg <= regReq.wdata;           // RQ5
               end
            endcase
         end
         else
         begin
            unique case (wdState_reg)
               WD_OFF: ;
               WD_RUN:
                  if (secTick)
                  begin
                     if (wdCount_reg == 8'h01)
                     begin
                        hostHwReset <= 1'b1;             // RQ3
                        wdState_reg <= WD_OFF;
                        wdCount_reg <= saw_pkg::WD_DISABLE;
                     end
                     else
                        wdCount_reg <= wdCount_reg - 8'h01; // RQ2
                  end
            endcase
         end
      end
   end

   // ----------------------------------------------------------------
   // serial port setting, committed on every change
   // ----------------------------------------------------------------
   logic [7:0] serial_reg;

   always_ff @(posedge sys_clk or negedge rstN)
   begin
      if (!rstN)
      begin
         serial_reg   <= saw_pkg::SERIAL_RESET_VAL;      // RQ8
         serialEnable <= 1'b0;
         nvmWrite     <= '0;
      end
      else
      begin
         nvmWrite.wr <= 1'b0;
         if (serWr && (regReq.wdata != serial_reg))
         begin
            serial_reg    <= regReq.wdata;
            nvmWrite.wr   <= 1'b1;                       // RQ9
            nvmWrite.addr <= saw_pkg::OFS_SERIAL_PORT;
            nvmWrite.data <= regReq.wdata;
         end
         serialEnable <= (serWr ? regReq.wdata : serial_reg) == saw_pkg::SERIAL_ON; // RQ8
      end
   end

   // ----------------------------------------------------------------
   // battery run time
   // ----------------------------------------------------------------
   typedef enum logic [2:0] {
      BT_CABLE = 3'b001,
      BT_COUNT = 3'b010,
      BT_SLEEP = 3'b100
   } saw_bat_state_t;

   function automatic logic [15:0] batLimit(input logic [7:0] set);
      batLimit = 16'(({8'h00, set} + 16'h0001) * saw_pkg::BAT_STEP_S);
   endfunction

   saw_bat_state_t batState_reg;
   logic [7:0]     batSet_reg;
   logic [15:0]    batSecs_reg;

   always_ff @(posedge sys_clk or negedge rstN)
   begin
      if (!rstN)
         batSet_reg <= saw_pkg::BAT_RESET_VAL;           // RQ10
      else if (batWr)
         batSet_reg <= regReq.wdata;
   end

   always_ff @(posedge sys_clk or negedge rstN)
   begin
      if (!rstN)
      begin
         batState_reg <= BT_CABLE;
         batSecs_reg  <= 16'h0000;
         batShutdown  <= 1'b0;
         hostRestart  <= 1'b0;
      end
      else
      begin
         batShutdown <= 1'b0;
         hostRestart <= 1'b0;
         unique case (batState_reg)
            BT_CABLE:
               if (batLevel_reg)
               begin
                  batState_reg <= BT_COUNT;
                  batSecs_reg  <= 16'h0000;
               end
            BT_COUNT:
               if (!batLevel_reg)
                  batState_reg <= BT_CABLE;
               else if (secTick && batSet_reg != saw_pkg::BAT_TIMER_OFF)
               begin
                  if (batSecs_reg + 16'h0001 >= batLimit(batSet_reg))
                  begin
                     batShutdown  <= 1'b1;               // RQ10
                     batState_reg <= BT_SLEEP;
                  end
                  else
                     batSecs_reg <= batSecs_reg + 16'h0001;
               end
            BT_SLEEP:
               if (btnPress || !batLevel_reg)
               begin
                  hostRestart  <= 1'b1;                  // RQ11
                  batSecs_reg  <= 16'h0000;
                  batState_reg <= batLevel_reg ? BT_COUNT : BT_CABLE;
               end
         endcase
      end
   end

   // ----------------------------------------------------------------
   // register read
   // ----------------------------------------------------------------
   always_ff @(posedge sys_clk or negedge rstN)
   begin
      if (!rstN)
      begin
         regRdData  <= 8'h00;
         regRdValid <= 1'b0;
      end
      else
      begin
         regRdValid <= regReq.rd;
         if (regReq.rd)
         begin
            unique case (regReq.addr)
               saw_pkg::OFS_STILL_ALIVE:  regRdData <= wdCount_reg; // RQ1
               saw_pkg::OFS_SERIAL_PORT:  regRdData <= serial_reg;
               saw_pkg::OFS_BAT_RUN_TIME: regRdData <= batSet_reg;
               default:                   regRdData <= 8'h00;
            endcase
         end
      end
   end

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rstN);

   sequence s_wd_load;
      wdWr && regReq.wdata != 8'h00 && regReq.wdata != 8'hFF;
   endsequence

   sequence s_wd_last_sec;
      !wdWr && wdState_reg == WD_RUN && wdCount_reg == 8'h01 && secTick;
   endsequence

   a_wd_load_value: assert property (s_wd_load |=> wdState_reg == WD_RUN // RQ2
      && wdCount_reg == $past(regReq.wdata))
      else $error("countdown load wrong");
   a_wd_step_down: assert property (!wdWr && wdState_reg == WD_RUN && secTick // RQ2
      && wdCount_reg > 8'h01 |=> wdCount_reg == $past(wdCount_reg) - 8'h01)
      else $error("countdown step wrong");
   a_wd_expiry_reset: assert property (s_wd_last_sec |=> hostHwReset ##1 !hostHwReset) // RQ3
      else $error("expiry reset pulse wrong");
   a_wd_no_spurious: assert property (hostHwReset |-> $past(wdState_reg) == WD_RUN) // RQ3
      else $error("reset without running countdown");
   a_wd_zero_shutdown: assert property (wdWr && regReq.wdata == 8'h00 |=> safeShutdown // RQ4
      && !hostHwReset) else $error("zero write no shutdown");
   a_wd_disable_ff: assert property (wdWr && regReq.wdata == 8'hFF |=> wdState_reg == WD_OFF // RQ7
      [*2]) else $error("disable failed");
   a_wd_read_live: assert property (regReq.rd && regReq.addr == 8'h05 && !wdWr // RQ1
      |=> regRdValid && regRdData == $past(wdCount_reg)) else $error("read value wrong");
   a_ser_commit: assert property (serWr && regReq.wdata != serial_reg |=> nvmWrite.wr // RQ9
      && nvmWrite.data == $past(regReq.wdata)) else $error("serial commit missing");
   a_ser_enable: assert property (##1 serialEnable == ($past(serWr) // RQ8
      ? $past(regReq.wdata) == 8'h01 : $past(serial_reg) == 8'h01))
      else $error("serial enable wrong");
   a_bat_limit: assert property (batShutdown |-> $past(batSecs_reg) + 16'h0001 // RQ10
      >= batLimit($past(batSet_reg))) else $error("battery shutdown early");
   a_bat_restart: assert property (batState_reg == BT_SLEEP && btnPress |=> hostRestart // RQ11
      && batSecs_reg == 16'h0000) else $error("button restart missing");

endmodule // saw_still_alive

// *** rtl/saw_tick_gen.sv ***
`timescale 1ns/100ps
module saw_tick_gen #(
   parameter int CYCLES = 50000000
) (
   // clock and reset
   input  wire logic sysClk,
   input  wire logic rstN,
   // one-cycle pulse every CYCLES clocks
   output logic      tick
);

   logic [31:0] divCnt_reg;

   always_ff @(posedge sysClk or negedge rstN)
   begin
      if (!rstN)
      begin
         divCnt_reg <= 32'h0000_0000;
         tick       <= 1'b0;
      end
      else if (divCnt_reg == 32'(CYCLES - 1))
      begin
         divCnt_reg <= 32'h0000_0000;
         tick       <= 1'b1;
      end
      else
      begin
         divCnt_reg <= divCnt_reg + 32'h0000_0001;
         tick       <= 1'b0;
      end
   end

endmodule // saw_tick_gen

// *** verification/saw_host_model.sv ***
`timescale 1ns/100ps
module saw_host_model (
   // clock
   input  wire logic            sysClk,
   // register port toward the block
   output saw_pkg::saw_regreq_t regReq,
   input  wire logic [7:0]      regRdData,
   input  wire logic            regRdValid
);
   initial
   begin
      regReq = '0;
   end

   // strobes change on falling edges only, so the rising edge sees them settled
   task automatic write_reg(input logic [7:0] addr, input logic [7:0] data);
   begin
      @(negedge sysClk);
      regReq = '{addr: addr, wr: 1'b1, rd: 1'b0, wdata: data};
      @(negedge sysClk);
      regReq.wr = 1'b0;
   end
   endtask

   task automatic read_reg(input logic [7:0] addr, output logic [7:0] data);
      int n;
   begin
      n = 0;
      @(negedge sysClk);
      regReq = '{addr: addr, wr: 1'b0, rd: 1'b1, wdata: 8'h00};
      @(negedge sysClk);
      regReq.rd = 1'b0;
      while (regRdValid !== 1'b1 && n < 3)
      begin
         @(negedge sysClk);
         n++;
      end
      data = (regRdValid === 1'b1) ? regRdData : 8'hXX;
   end
   endtask

   // fresh reload well inside the running count keeps the host alive
   task automatic kick(input logic [7:0] val);
   begin
      write_reg(saw_pkg::OFS_STILL_ALIVE, val);
   end
   endtask
endmodule // saw_host_model

// *** verification/still_alive_watchdog_regs_tb_top.sv ***
`timescale 1ns/100ps
module still_alive_watchdog_regs_tb_top;
   // ----------------------------------------------------------------
   // signals
   // ----------------------------------------------------------------
   localparam int TICK  = 10;
   localparam int LIMIT = 10000;
   logic                 sysClk;
   logic                 resetN;
   logic                 onBattery;
   logic                 funcButtonN;
   saw_pkg::saw_regreq_t regReq;
   saw_pkg::saw_nvmwr_t  nvmWrite;
   logic [7:0]           regRdData;
   logic                 regRdValid;
   logic                 hostHwReset;
   logic                 safeShutdown;
   logic                 batShutdown;
   logic                 hostRestart;
   logic                 serialEnable;
   logic [4:0]           evts;
   int                   evCnt [5];
   int                   errCount;
   int                   numChecks;
   int                   cyc;
   logic [7:0]           r;
   int                   n;

   assign evts = {nvmWrite.wr, hostRestart, batShutdown, safeShutdown, hostHwReset};

   initial
   begin
      sysClk = 1'b0;
      forever #10 sysClk = ~sysClk;
   end

   saw_still_alive #(.TICK_CYCLES(TICK)) i_dut (
      .sys_clk(sysClk), .resetn(resetN), .regReq(regReq), .regRdData(regRdData),
      .regRdValid(regRdValid), .onBattery(onBattery), .funcButtonN(funcButtonN),
      .hostHwReset(hostHwReset), .safeShutdown(safeShutdown), .batShutdown(batShutdown),
      .hostRestart(hostRestart), .serialEnable(serialEnable), .nvmWrite(nvmWrite));

   saw_host_model i_host (
      .sysClk(sysClk), .regReq(regReq), .regRdData(regRdData), .regRdValid(regRdValid));

   always @(posedge sysClk)
   begin
      for (int i = 0; i < 5; i++)
      begin
         if (evts[i] === 1'b1)
         begin
            evCnt[i]++;
         end
      end
      cyc++;
      if (cyc == LIMIT)
      begin
         errCount++;
         finishTest();
      end
   end

   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
   begin
      numChecks++;
      if (seen !== exp)
      begin
         errCount++;
         $display("MISMATCH %s expected %h seen %h", what, exp, seen);
      end
   end
   endtask

   // cycles until the chosen event pulse shows, capped at maxc
   task automatic waitEvt(input int sel, input int maxc, output int cnt);
   begin
      cnt = 0;
      while (evts[sel] !== 1'b1 && cnt < maxc)
      begin
         @(negedge sysClk);
         cnt++;
      end
   end
   endtask

   task automatic finishTest;
   begin
      $display("checks %0d errors %0d", numChecks, errCount);
      if (errCount == 0 && numChecks > 0)
      begin
         $display("ALL CHECKS OK");
      end
      else
      begin
         $display("CHECKS NOT OK");
      end
      $finish;
   end
   endtask

   // ----------------------------------------------------------------
   // scenarios
   // ----------------------------------------------------------------
   task automatic testResetValues;
   begin
      i_host.read_reg(saw_pkg::OFS_STILL_ALIVE, r);
      check("countdown reset", r, 8'hFF);
      i_host.read_reg(saw_pkg::OFS_SERIAL_PORT, r);
      check("serial reset", r, 8'h00);
      check("serial enable", serialEnable, 1'b0);
      i_host.read_reg(saw_pkg::OFS_BAT_RUN_TIME, r);
      check("bat reset", r, 8'h00);
      i_host.read_reg(8'h07, r);
      check("unmapped read", r, 8'h00);
   end
   endtask

   // battery power must not stop the watchdog; bat timer is switched off first
   task automatic testExpiry(input logic bat);
      int hw;
      int bs;
      logic [7:0] r2;
   begin
      bs = evCnt[2];
      i_host.write_reg(saw_pkg::OFS_BAT_RUN_TIME, 8'hFF);
      onBattery = bat;
      repeat (5) @(negedge sysClk);
      hw = evCnt[0];
      i_host.write_reg(saw_pkg::OFS_STILL_ALIVE, 8'h03);
      i_host.read_reg(saw_pkg::OFS_STILL_ALIVE, r);
      i_host.read_reg(saw_pkg::OFS_STILL_ALIVE, r2);
      check("loaded", r == 8'h03 || r == 8'h02, 1'b1);
      check("read keeps", r2 <= r && r2 >= r - 8'h01, 1'b1);
      waitEvt(0, 60, n);
      check("expiry time", n >= 12 && n <= 32, 1'b1);
      @(negedge sysClk);
      check("one reset", evCnt[0] - hw, 16'h0001);
      i_host.read_reg(saw_pkg::OFS_STILL_ALIVE, r);
      check("after expiry", r, 8'hFF);
      check("bat timer off", evCnt[2] - bs, 16'h0000);
      onBattery = 1'b0;
   end
   endtask

   task automatic testKickAndDisable;
      int hw;
   begin
      hw = evCnt[0];
      i_host.kick(8'h04);
      repeat (5)
      begin
         repeat (15) @(negedge sysClk);
         i_host.kick(8'h04);
      end
      i_host.write_reg(saw_pkg::OFS_STILL_ALIVE, saw_pkg::WD_DISABLE);
      repeat (80) @(negedge sysClk);
      check("no reset", evCnt[0] - hw, 16'h0000);
      i_host.read_reg(saw_pkg::OFS_STILL_ALIVE, r);
      check("disabled", r, 8'hFF);
   end
   endtask

   task automatic testSafeShutdown;
      int hw;
   begin
      hw = evCnt[0];
      i_host.write_reg(saw_pkg::OFS_STILL_ALIVE, 8'h05);
      i_host.write_reg(saw_pkg::OFS_STILL_ALIVE, saw_pkg::WD_SAFE_SHUTDOWN);
      waitEvt(1, 3, n);
      check("safe shutdown", n <= 1, 1'b1);
      repeat (70) @(negedge sysClk);
      check("no hw reset", evCnt[0] - hw, 16'h0000);
   end
   endtask

   task automatic testSerial(input logic [7:0] val);
   begin
      fork
         i_host.write_reg(saw_pkg::OFS_SERIAL_PORT, val);
         waitEvt(4, 4, n);
      join
      check("nvm commit", n < 4, 1'b1);
      check("nvm addr", nvmWrite.addr, 8'h02);
      check("nvm data", nvmWrite.data, val);
      @(negedge sysClk);
      check("serial on", serialEnable, val == 8'h01);
      i_host.read_reg(saw_pkg::OFS_SERIAL_PORT, r);
      check("serial read", r, val);
      n = evCnt[4];
      i_host.write_reg(saw_pkg::OFS_SERIAL_PORT, val);
      repeat (2) @(negedge sysClk);
      check("no repeat commit", evCnt[4] - n, 16'h0000);
      check("serial kept", serialEnable, val == 8'h01);
   end
   endtask

   // 0x00 setting gives 60 ticks on battery, then again after a button restart
   task automatic testBattery;
   begin
      i_host.write_reg(saw_pkg::OFS_BAT_RUN_TIME, 8'h00);
      onBattery = 1'b1;
      waitEvt(2, 700, n);
      check("bat run time", n >= 590 && n <= 616, 1'b1);
      repeat (20) @(negedge sysClk);
      funcButtonN = 1'b0;
      waitEvt(3, 12, n);
      check("button restart", n < 12, 1'b1);
      funcButtonN = 1'b1;
      @(negedge sysClk);
      waitEvt(2, 700, n);
      check("second run", n >= 588 && n <= 614, 1'b1);
      onBattery = 1'b0;
      waitEvt(3, 12, n);
      check("cable restart", n < 12, 1'b1);
   end
   endtask

   initial
   begin
      resetN = 1'b0;
      onBattery = 1'b0;
      funcButtonN = 1'b1;
      errCount = 0;
      numChecks = 0;
      cyc = 0;
      repeat (10) @(negedge sysClk);
      resetN = 1'b1;
      repeat (3) @(negedge sysClk);
      testResetValues();
      testExpiry(1'b0);
      testExpiry(1'b1);
      testKickAndDisable();
      testSafeShutdown();
      testSerial(saw_pkg::SERIAL_ON);
      testSerial(saw_pkg::SERIAL_OFF);
      testBattery();
      finishTest();
   end
endmodule // still_alive_watchdog_regs_tb_top
